//--- supply_detect_ctrl.sv
// supply detector control with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module supply_detect_ctrl
  import supply_detect_pkg::*;
#(
  parameter int THREE_LEVEL = 1 // 1: upper select bit present
) (
  input wire logic clk,
  input wire logic rst_b,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analogue comparator side
  input wire logic cmpBelowAsync,
  output logic cmpEnable,
  output logic [1:0] thresholdSel,
  // events to the rest of the chip
  output logic supplyCrossIrq,
  output logic supplyLowReset
);

  // refuse a variant flag the logic cannot serve
  if (THREE_LEVEL != 0 && THREE_LEVEL != 1) begin : g_check
    $error("THREE_LEVEL must be 0 or 1");
  end

  // write channel holding registers
  logic awHeld_reg; // address taken, waiting for data
  logic [29:0] awIdx_reg; // word index of held address
  logic wHeld_reg; // data taken, waiting for address
  logic [7:0] wData_reg; // low byte of held data
  logic wLane_reg; // low byte lane enabled
  wr_state_t wrState_reg;
  logic [1:0] bresp_reg;

  // read channel registers
  rd_state_t rdState_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // register contents
  logic enable_reg; // detect_enable
  logic mode_reg; // detect_mode_select
  logic [1:0] thr_reg; // threshold_sel_hi, threshold_sel_lo
  logic cause_reg; // supply_reset_cause_flag

  // event logic
  logic belowSync; // filtered comparator level
  logic prevBelow_reg; // level one cycle earlier
  logic irq_reg;
  logic lowReset_reg;

  // decode results
  logic wrStb; // both halves of a write present
  logic wrHit;
  logic lock; // reset mode latched in
  logic flag; // below_threshold_flag
  logic crossing;
  logic rstRequest;
  logic rstFire; // first cycle of a detector reset
  logic ctrlWrite;
  logic thrWrite;
  logic causeWrite;
  logic [1:0] thrNew;
  logic [7:0] ctrlView;
  logic [7:0] rdByte;
  logic rdHit;
  logic [29:0] rdIdx;

  unlock_if unlock ();

  // comparator output crosses into the clock domain
  input_sync3 u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn(cmpBelowAsync),
    .levelOut(belowSync)
  );

  // key sequence guarding the control register
  protect_gate u_gate (
    .clk(clk),
    .rst_b(rst_b),
    .port(unlock.gate)
  );

  // handshake outputs
  assign awready = !awHeld_reg;
  assign wready = !wHeld_reg;
  assign bvalid = (wrState_reg == WR_RESP);
  assign bresp = bresp_reg;
  assign arready = (rdState_reg == RD_IDLE);
  assign rvalid = (rdState_reg == RD_DATA);
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // a write fires once address and data are both held
  assign wrStb = awHeld_reg && wHeld_reg && (wrState_reg == WR_IDLE);
  assign wrHit = (awIdx_reg == CTRL_IDX) || (awIdx_reg == THR_IDX)
    || (awIdx_reg == KEY_IDX) || (awIdx_reg == CAUSE_IDX);

  // feed the protected-write gate
  assign unlock.wrStb = wrStb;
  assign unlock.toKey = (awIdx_reg == KEY_IDX) && wLane_reg;
  assign unlock.toGuarded = (awIdx_reg == CTRL_IDX) && wLane_reg;
  assign unlock.wrData = wData_reg;

  // lock once enable and reset mode are both set
  assign lock = enable_reg && mode_reg; // RULE7

  // control update: guarded, refused under lock
  assign ctrlWrite = unlock.grant && !lock; // RULE7 RULE18

  // threshold update: refused under lock, and never to the prohibited code
  assign thrWrite = wrStb && (awIdx_reg == THR_IDX) && wLane_reg && !lock
    && (thrNew != SEL_PROHIBITED); // RULE8 RULE9
  assign causeWrite = wrStb && (awIdx_reg == CAUSE_IDX) && wLane_reg;

  // the two-level variant has no upper select bit
  assign thrNew = (THREE_LEVEL == 1) ? wData_reg[1:0] : {1'b0, wData_reg[0]}; // RULE9

  // flag shows the live level, zero while disabled
  assign flag = enable_reg && belowSync; // RULE3

  // interrupt mode: any change of the filtered level
  assign crossing = enable_reg && !mode_reg && (belowSync != prevBelow_reg); // RULE1

  // reset mode: request held while the supply stays low
  assign rstRequest = enable_reg && mode_reg && belowSync; // RULE2
  assign rstFire = rstRequest && !lowReset_reg;

  // comparator powered only while enabled
  assign cmpEnable = enable_reg; // RULE19
  assign thresholdSel = thr_reg;

  // flag bit comes from live state, never from a write
  always_comb begin
    ctrlView = 8'h00;
    ctrlView[ENABLE_BIT] = enable_reg;
    ctrlView[MODE_BIT] = mode_reg;
    ctrlView[FLAG_BIT] = flag; // RULE3 RULE4
  end

  // read decode
  assign rdIdx = araddr[31:2];
  always_comb begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    case (rdIdx)
      CTRL_IDX: rdByte = ctrlView;
      THR_IDX: rdByte = {6'h00, thr_reg};
      KEY_IDX: rdByte = 8'h00; // key reads back as zero
      CAUSE_IDX: rdByte = {7'h00, cause_reg};
      default: rdHit = 1'b0;
    endcase
  end

  // write address capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_reg <= 1'b0;
      awIdx_reg <= 30'h0;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awIdx_reg <= awaddr[31:2];
    end else if (wrStb) begin
      awHeld_reg <= 1'b0;
    end
  end

  // write data capture; only the low lane carries register bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= wdata[7:0];
      wLane_reg <= wstrb[0]; // RULE4
    end else if (wrStb) begin
      wHeld_reg <= 1'b0;
    end
  end

  // write response; unmapped addresses answer with an error
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrState_reg <= WR_IDLE;
      bresp_reg <= RESP_OKAY;
    end else begin
      case (wrState_reg)
        WR_IDLE: begin
          if (wrStb) begin
            wrState_reg <= WR_RESP;
            bresp_reg <= wrHit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wrState_reg <= WR_IDLE;
          end
        end
        default: wrState_reg <= WR_IDLE;
      endcase
    end
  end

  // read channel; data registered at address acceptance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdState_reg <= RD_IDLE;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else begin
      case (rdState_reg)
        RD_IDLE: begin
          if (arvalid) begin
            rdState_reg <= RD_DATA;
            rdata_reg <= {24'h0, rdByte};
            rresp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_DATA: begin
          if (rready) begin
            rdState_reg <= RD_IDLE;
          end
        end
        default: rdState_reg <= RD_IDLE;
      endcase
    end
  end

  // control bits; a detector reset reloads them, outside resets clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= CTRL_OTHER_RST[ENABLE_BIT]; // RULE5
      mode_reg <= CTRL_OTHER_RST[MODE_BIT];
    end else if (rstFire) begin
      enable_reg <= CTRL_DETECT_RST[ENABLE_BIT]; // RULE5
      mode_reg <= CTRL_DETECT_RST[MODE_BIT];
    end else if (ctrlWrite) begin
      // flag bit and bits 6..2 of the write are dropped
      enable_reg <= wData_reg[ENABLE_BIT]; // RULE4
      mode_reg <= wData_reg[MODE_BIT];
    end
  end

  // threshold select survives a detector reset: no rstFire term here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_reg <= THR_OTHER_RST; // RULE6
    end else if (thrWrite) begin
      thr_reg <= thrNew;
    end
  end

  // reset cause flag; a new detector reset beats a software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_reg <= 1'b0;
    end else if (rstFire) begin
      cause_reg <= 1'b1; // RULE17
    end else if (causeWrite && !wData_reg[0]) begin
      cause_reg <= 1'b0;
    end
  end

  // level history for crossing detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevBelow_reg <= 1'b0;
    end else begin
      prevBelow_reg <= belowSync;
    end
  end

  // event outputs; free-running clock keeps them alive in standby
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
      lowReset_reg <= 1'b0;
    end else begin
      irq_reg <= crossing; // RULE1 RULE16
      lowReset_reg <= rstRequest; // RULE2 RULE16
    end
  end

  assign supplyCrossIrq = irq_reg;
  assign supplyLowReset = lowReset_reg;

endmodule : supply_detect_ctrl

//--- supply_detect_pkg.sv
// constants and types for the supply detector control block
// Summary of operation
// RULE1 - mode 0: interrupt on either threshold crossing
// RULE2 - mode 1: internal reset when supply drops
// RULE3 - flag high only while enabled and below
// RULE4 - byte access; flag bit ignores writes
// RULE5 - control holds 82H after own reset
// RULE6 - threshold kept over own reset only
// RULE7 - enable plus mode locks control register
// RULE8 - lock also blocks threshold register writes
// RULE9 - threshold codes 00, 01, 10; 11 prohibited
// RULE10 - software writes zero to unused bits
// RULE11 - software waits 0.2 ms after enabling
// RULE12 - no disable while flag shows below
// RULE13 - reset use: fixed software start order
// RULE14 - interrupt use: fixed software start order
// RULE15 - stop: check flag, then clear enable
// RULE16 - detector keeps running in standby modes
// RULE17 - own reset sets the cause flag
// RULE18 - control writes need protected sequence
// RULE19 - comparator runs only while enabled
// RULE20 - comparator output synchronised before use
package supply_detect_pkg;
  // register indices; byte address is four times the index
  localparam logic [29:0] CTRL_IDX = 30'h0ffff890;
  localparam logic [29:0] THR_IDX = 30'h0ffff891;
  localparam logic [29:0] KEY_IDX = 30'h0ffff892;
  localparam logic [29:0] CAUSE_IDX = 30'h0ffff893;
  // control register field positions
  localparam int ENABLE_BIT = 7;
  localparam int MODE_BIT = 1;
  localparam int FLAG_BIT = 0;
  // threshold field
  localparam logic [1:0] SEL_PROHIBITED = 2'h3;
  // reset values
  localparam logic [7:0] CTRL_DETECT_RST = 8'h82;
  localparam logic [7:0] CTRL_OTHER_RST = 8'h00;
  localparam logic [1:0] THR_OTHER_RST = 2'h0;
  // protected-write key
  localparam logic [7:0] PROTECT_KEY = 8'ha5;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // comparator settling, waited out by software
  localparam int SETTLE_TIME_NS = 200000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus channel states
  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;
endpackage : supply_detect_pkg

//--- unlock_if.sv
// interface between the bus decode and the protected-write gate
`timescale 1ns/1ps
interface unlock_if;
  logic wrStb; // one register write this cycle
  logic toKey; // write targets the key register
  logic toGuarded; // write targets the control register
  logic [7:0] wrData; // low byte of the write
  logic grant; // guarded write may take effect
  modport decode (output wrStb, output toKey, output toGuarded, output wrData, input grant);
  modport gate (input wrStb, input toKey, input toGuarded, input wrData, output grant);
endinterface : unlock_if

//--- input_sync3.sv
// three-flop synchroniser with agreement filter
`timescale 1ns/1ps
module input_sync3 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic asyncIn,
  output logic levelOut
);
  logic ff1_reg; // only read by ff2_reg
  logic ff2_reg;
  logic ff3_reg;

  // shift chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff1_reg <= 1'b0;
      ff2_reg <= 1'b0;
      ff3_reg <= 1'b0;
    end else begin
      ff1_reg <= asyncIn;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // accept a change only once two stages agree, filtering glitches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      levelOut <= 1'b0;
    end else if (ff2_reg == ff3_reg) begin
      levelOut <= ff3_reg; // RULE20
    end
  end
endmodule : input_sync3

//--- protect_gate.sv
// protected write sequence: key write arms the next write
`timescale 1ns/1ps
module protect_gate
  import supply_detect_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  unlock_if.gate port
);
  logic armed_reg; // key seen, next write may pass

  // any write consumes the arming; only the key write sets it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
    end else if (port.wrStb) begin
      armed_reg <= port.toKey && (port.wrData == PROTECT_KEY); // RULE18
    end
  end

  // grant only on the write right after the key
  assign port.grant = armed_reg && port.wrStb && port.toGuarded; // RULE18
endmodule : protect_gate

//--- supply_detect_ctrl_asserts.sv
// port assertions for the supply detector control
`timescale 1ns/1ps
module supply_detect_ctrl_asserts
  import supply_detect_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic cmpBelowAsync,
  input wire logic cmpEnable,
  input wire logic [1:0] thresholdSel,
  input wire logic supplyCrossIrq,
  input wire logic supplyLowReset
);
  // single domain, reset from other sources
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // crossing event lasts one cycle
  irq_pulse_a: assert property (supplyCrossIrq |=> !supplyCrossIrq)
    else $error("crossing pulse too long");
  // raw comparator edge must not reach the event at once
  sync_delay_a: assert property ($changed(cmpBelowAsync) |=> !supplyCrossIrq [*2])
    else $error("crossing event skipped synchroniser");
  // reset request only when the comparator read low three cycles earlier
  lowrst_cause_a: assert property ($rose(supplyLowReset) |-> $past(cmpBelowAsync, 3))
    else $error("reset without low supply");
  // no crossing event while the reset request is out
  mode_excl_a: assert property (supplyLowReset |-> !supplyCrossIrq)
    else $error("event during reset request");
  // detector reset keeps the comparator running
  lock_hold_a: assert property (supplyLowReset |=> cmpEnable [*8])
    else $error("locked enable dropped");
  // threshold frozen while the reset request holds
  thr_frozen_a: assert property (supplyLowReset |=> $stable(thresholdSel))
    else $error("threshold moved while locked");
  // prohibited code never reaches the comparator
  thr_legal_a: assert property (thresholdSel != SEL_PROHIBITED)
    else $error("prohibited threshold selected");
  // read answer one cycle after acceptance
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  // address slot still taken the cycle after acceptance
  wr_accept_a: assert property (awvalid && awready |=> !awready)
    else $error("address slot not held");
  cover property (supplyCrossIrq);
  cover property (supplyLowReset);
  cover property (arvalid && arready);
endmodule : supply_detect_ctrl_asserts

//--- supply_comparator_model.sv
// behavioural analogue supply comparator
`timescale 1ns/1ps
module supply_comparator_model (
  input wire logic cmpEnable,
  input wire logic [1:0] thresholdSel,
  input int supplyMv,
  output logic cmpBelowAsync
);
  int thrMv; // trip point in millivolts
  // trip point per select code
  always_comb begin
    case (thresholdSel)
      2'h0: thrMv = 2800;
      2'h1: thrMv = 2300;
      2'h2: thrMv = 2100;
      default: thrMv = 0; // prohibited, never trips
    endcase
  end
  // idle comparator reports not below
  assign cmpBelowAsync = cmpEnable && (supplyMv < thrMv);
endmodule : supply_comparator_model

//--- supply_detect_ctrl_tb.sv
// self-checking bench for the supply detector control
`timescale 1ns/1ps
module supply_detect_ctrl_tb;
  import supply_detect_pkg::*;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cmpBelowAsync, cmpEnable;
  logic supplyCrossIrq, supplyLowReset;
  logic [31:0] awaddr, wdata, araddr, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, thresholdSel;
  int supplyMv, error_cnt, checks_done, cycles, n;
  supply_detect_ctrl u_supply_detect_ctrl (.clk, .rst_b, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .cmpBelowAsync, .cmpEnable, .thresholdSel,
    .supplyCrossIrq, .supplyLowReset);
  supply_comparator_model u_supply_comparator_model (.cmpEnable, .thresholdSel,
    .supplyMv, .cmpBelowAsync);
  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, well above the two settle waits
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  // one write, each channel released when taken
  task wr(input logic [29:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  // one read, data taken at the answer edge
  task rd(input logic [29:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rdv = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  // key write then guarded control write
  task pw(input logic [7:0] d);
    wr(KEY_IDX, PROTECT_KEY);
    wr(CTRL_IDX, d);
  endtask : pw
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  // count crossing pulses over a window past the sync delay
  task watch(output int k);
    k = 0;
    repeat (12) begin
      @(posedge clk);
      if (supplyCrossIrq === 1'b1) k++;
    end
  endtask : watch
  // reset values straight after an outside reset
  task t_reset;
    rd(CTRL_IDX);
    chk("reset ctrl", 32'h0, rdv);
    rd(THR_IDX);
    chk("reset thr", 32'h0, rdv);
    $display("test reset done");
  endtask : t_reset
  task t_regs;
    wr(CTRL_IDX, 8'h80);
    rd(CTRL_IDX);
    chk("unkeyed ctrl", 32'h0, rdv);
    for (int i = 0; i < 4; i++) begin
      wr(THR_IDX, 8'(i));
      rd(THR_IDX);
      chk("thr code", (i == 3) ? 32'h2 : 32'(i), rdv);
      chk("thr pins", (i == 3) ? 32'h2 : 32'(i), {30'h0, thresholdSel});
    end
    wr(THR_IDX, 8'h01);
    chk("thr wr resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    // low byte lane off: the write must leave the register alone
    wstrb <= 4'h2;
    wr(THR_IDX, 8'h00);
    wstrb <= 4'h1;
    rd(THR_IDX);
    chk("lane off thr", 32'h1, rdv);
    wr(30'h0ffff8a0, 8'h00);
    chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(30'h0ffff8a0);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("test regs done");
  endtask : t_regs
  task t_irq;
    pw(8'h81);
    rd(CTRL_IDX);
    chk("flag write", 32'h80, rdv);
    chk("cmp enable", 32'h1, {31'h0, cmpEnable});
    repeat (SETTLE_CYCLES) @(posedge clk);
    rd(CTRL_IDX);
    chk("flag settled", 32'h80, rdv);
    supplyMv <= 2200;
    watch(n);
    chk("fall event", 32'h1, n);
    rd(CTRL_IDX);
    chk("flag below", 32'h81, rdv);
    supplyMv <= 2500;
    watch(n);
    chk("rise event", 32'h1, n);
    rd(CTRL_IDX);
    chk("flag above", 32'h80, rdv);
    pw(8'h00);
    supplyMv <= 2200;
    watch(n);
    chk("idle event", 32'h0, n);
    rd(CTRL_IDX);
    chk("flag idle", 32'h0, rdv);
    supplyMv <= 2500;
    watch(n);
    $display("test irq done");
  endtask : t_irq
  task t_lock;
    pw(8'h80);
    repeat (SETTLE_CYCLES) @(posedge clk);
    rd(CTRL_IDX);
    chk("flag clear", 32'h80, rdv);
    pw(8'h82);
    pw(8'h00);
    rd(CTRL_IDX);
    chk("locked ctrl", 32'h82, rdv);
    wr(THR_IDX, 8'h00);
    rd(THR_IDX);
    chk("locked thr", 32'h1, rdv);
    supplyMv <= 2200;
    watch(n);
    chk("reset mode event", 32'h0, n);
    chk("low reset", 32'h1, {31'h0, supplyLowReset});
    rd(CAUSE_IDX);
    chk("cause", 32'h1, {31'h0, rdv[0]});
    rd(CTRL_IDX);
    chk("own reset ctrl", 32'h83, rdv);
    rd(THR_IDX);
    chk("own reset thr", 32'h1, rdv);
    wr(CAUSE_IDX, 8'h00);
    rd(CAUSE_IDX);
    chk("cause clear", 32'h0, rdv);
    supplyMv <= 2500;
    watch(n);
    chk("reset released", 32'h0, {31'h0, supplyLowReset});
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(CTRL_IDX);
    chk("other reset ctrl", 32'h0, rdv);
    rd(THR_IDX);
    chk("other reset thr", 32'h0, rdv);
    pw(8'h80);
    rd(CTRL_IDX);
    chk("unlocked ctrl", 32'h80, rdv);
    $display("test lock done");
  endtask : t_lock
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h1;
    supplyMv = 2500;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_irq();
    t_lock();
    end_sim();
  end
endmodule : supply_detect_ctrl_tb
bind supply_detect_ctrl supply_detect_ctrl_asserts u_asserts (.clk, .rst_b, .awvalid,
  .awready, .arvalid, .arready, .rvalid, .cmpBelowAsync, .cmpEnable, .thresholdSel,
  .supplyCrossIrq, .supplyLowReset);
